//--- common/isp_pkg.sv
// package for the i2c slave page-write port: constants and carrier types
// assumes one system clock at 50 MHz; scl and sda arrive asynchronously
package isp_pkg;

  // ----------------------------------------
  // addressing and framing
  // ----------------------------------------
  localparam logic [6:0] ISP_SLAVE_ADDR = 7'h6B;
  localparam logic [3:0] ISP_BIT_LAST = 4'h7;
  localparam logic [3:0] ISP_BIT_ACK = 4'h8;
  localparam int ISP_ROW_BYTES = 8;
  localparam logic [2:0] ISP_ROW_LAST = 3'h7;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int ISP_CLK_HZ = 50_000_000;
  localparam int ISP_NVM_PROGRAM_TIME_US = 10;
  localparam int ISP_NVM_PROGRAM_CYCLES = ISP_NVM_PROGRAM_TIME_US * (ISP_CLK_HZ / 1_000_000);

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] ISP_ADDR_RST = 8'h00;
  localparam logic [2:0] ISP_SYNC_RST = 3'h7;

  typedef enum logic [2:0] {
    ISP_IDLE,
    ISP_ADDR,
    ISP_PTR,
    ISP_WDATA,
    ISP_RDATA,
    ISP_IGNORE
  } isp_phase_e;

  // memory-side write request and nvm commit request
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } isp_mem_wr_s;

  typedef struct packed {
    logic commit;
    logic [7:0] row_addr;
    logic [3:0] count;
  } isp_nvm_req_s;

  // open-drain pin pair
  typedef struct packed {
    logic o;
    logic oe;
  } isp_pin_out_s;

endpackage

//--- rtl/isp_slave.sv
// i2c slave port: start/stop detect, byte shifting, address match,
// row-limited write auto-increment, nvm commit after stop, busy polling.
// assumes scl and sda are raw pins sampled by sys_clk at many times the
// bit rate; the memory answers rd_data combinationally for mem_addr.
`timescale 1ns/10ps

// Notes on behaviour
// - sda falling while scl high is a start and opens a transfer.
// - sda rising while scl high is a stop and ends the transfer.
// - repeated start is detected like start and begins a new transfer.
// - bus idle between stop and start, both lines released high.
// - incoming bits sampled on scl rising edge; sda only changes while scl low.
// - outgoing bits change on scl falling edge, valid at next rising edge.
// - ninth bit is acknowledge; low means ack, released means nack.
// - bytes are eight bits, msb first, then an acknowledge.
// - master nacks the last read byte; device then releases sda.
// - first byte after start: 7-bit address plus direction bit, one means read.
// - device answers address 1101011, bytes d6h write and d7h read.
// - wrong address gets no ack; bus ignored until next start.
// - second byte of a write loads the address counter.
// - device acknowledges address, pointer and each data byte of a write.
// - nvm programming starts only after the stop ending the write.
// - write ended by repeated start updates shadow only, no nvm program.
// - each further data byte goes to the next address.
// - one to eight data bytes per write, inside one 8-byte row.
// - on writes the address counter wraps to the start of the same row; reads run on across rows.
// - slave address not acknowledged while nvm programming runs.
// - reads start at the address counter and advance per byte sent, acked or not.
module isp_slave #(
  parameter int NVM_PROGRAM_CYCLES = isp_pkg::ISP_NVM_PROGRAM_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  output isp_pkg::isp_pin_out_s sda_out,
  output isp_pkg::isp_mem_wr_s mem_wr,
  output logic [7:0] mem_addr,
  input wire logic [7:0] rd_data,
  output isp_pkg::isp_nvm_req_s nvm_req,
  output logic nvm_busy
);
  import isp_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    isp_phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] tx;
    logic ack_phase;
    logic ack_ok;
    logic master_nack;
    logic [7:0] addr;
    logic [7:0] row_addr;
    logic [3:0] wr_count;
    logic pending;
    logic sda_low;
    logic wr_pulse;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic commit;
    logic [31:0] busy_cnt;
  } isp_state_s;

  isp_state_s st_ff;
  isp_state_s nxt_st;

  logic scl_s;
  logic sda_s;
  logic scl_prev;
  logic sda_prev;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic busy;
  logic active;
  logic addr_hit;
  logic byte_done;
  logic ninth_end;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // row-confined increment: low three bits wrap, row bits stay
  function automatic logic [7:0] isp_row_inc(input logic [7:0] a);
    isp_row_inc = {a[7:3], a[2:0] + 3'h1};
  endfunction

  // first location of the row that holds a
  function automatic logic [7:0] isp_row_base(input logic [7:0] a);
    isp_row_base = {a[7:3], 3'h0};
  endfunction

  // open drain: a zero bit is sent by pulling the line low
  function automatic logic isp_pull_low(input logic b);
    isp_pull_low = !b;
  endfunction

  // idle and ignore phases leave the bit engine parked
  function automatic logic isp_engaged(input isp_phase_e p);
    isp_engaged = (p != ISP_IDLE) && (p != ISP_IGNORE);
  endfunction

  // ----------------------------------------
  // pin sampling and edge detection
  // ----------------------------------------
  // bit 0 is the metastable stage; only bits 1 and 2 feed logic
  assign scl_s = st_ff.scl_sync[1];
  assign sda_s = st_ff.sda_sync[1];
  assign scl_prev = st_ff.scl_sync[2];
  assign sda_prev = st_ff.sda_sync[2];
  assign scl_rise = scl_s && !scl_prev;
  assign scl_fall = !scl_s && scl_prev;
  assign start_det = scl_s && scl_prev && sda_prev && !sda_s;
  assign stop_det = scl_s && scl_prev && !sda_prev && sda_s;
  assign busy = (st_ff.busy_cnt != 32'h0);

  // ----------------------------------------
  // decoded events
  // ----------------------------------------
  assign active = isp_engaged(st_ff.phase);
  // busy refuses only the address byte; a transfer under way runs on
  assign addr_hit = (st_ff.shift[7:1] == ISP_SLAVE_ADDR) && !busy;
  assign byte_done = scl_fall && !st_ff.ack_phase && (st_ff.bit_cnt == ISP_BIT_ACK);
  assign ninth_end = scl_fall && st_ff.ack_phase;

  always_comb begin
    nxt_st = st_ff;

    // ----------------------------------------
    // synchronisers and one-cycle pulses
    // ----------------------------------------
    nxt_st.scl_sync = {st_ff.scl_sync[1:0], scl_i};
    nxt_st.sda_sync = {st_ff.sda_sync[1:0], sda_i};
    nxt_st.wr_pulse = 1'b0;
    nxt_st.commit = 1'b0;

    // ----------------------------------------
    // programming countdown
    // ----------------------------------------
    if (busy) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - 32'h1;
    end

    // ----------------------------------------
    // framing conditions
    // ----------------------------------------
    if (start_det) begin
      // repeated start keeps shadow data but drops the nvm commit
      nxt_st.pending = 1'b0;
      nxt_st.wr_count = 4'h0;
      nxt_st.phase = ISP_ADDR;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.ack_phase = 1'b0;
      nxt_st.sda_low = 1'b0;
    end else if (stop_det) begin
      // a pointer-only write leaves nothing pending, so no commit
      if (st_ff.pending) begin
        nxt_st.commit = 1'b1;
        nxt_st.busy_cnt = 32'(NVM_PROGRAM_CYCLES);
      end
      nxt_st.pending = 1'b0;
      nxt_st.phase = ISP_IDLE;
      nxt_st.bit_cnt = 4'h0;
      nxt_st.ack_phase = 1'b0;
      nxt_st.sda_low = 1'b0;
    end else if (active) begin
      // ----------------------------------------
      // bit engine
      // ----------------------------------------
      if (scl_rise) begin
        if (!st_ff.ack_phase) begin
          nxt_st.shift = {st_ff.shift[6:0], sda_s};
          nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        end else begin
          nxt_st.master_nack = sda_s;
        end
      end
      // ----------------------------------------
      // falling edge: acknowledge and outgoing bits
      // ----------------------------------------
      if (scl_fall) begin
        if (byte_done) begin
          // eighth bit done: decide the acknowledge
          nxt_st.ack_phase = 1'b1;
          nxt_st.ack_ok = 1'b0;
          unique case (st_ff.phase)
            ISP_ADDR: begin
              nxt_st.ack_ok = addr_hit;
            end
            ISP_PTR: begin
              nxt_st.ack_ok = 1'b1;
              nxt_st.addr = st_ff.shift;
              nxt_st.row_addr = isp_row_base(st_ff.shift);
            end
            ISP_WDATA: begin
              nxt_st.ack_ok = 1'b1;
              nxt_st.wr_pulse = 1'b1;
              nxt_st.wr_addr = st_ff.addr;
              nxt_st.wr_data = st_ff.shift;
              nxt_st.addr = isp_row_inc(st_ff.addr);
              nxt_st.pending = 1'b1;
              if (st_ff.wr_count != 4'(ISP_ROW_BYTES)) begin
                nxt_st.wr_count = st_ff.wr_count + 4'h1;
              end
            end
            ISP_RDATA: begin
              nxt_st.ack_ok = 1'b0; // receiver is the master here
            end
            default: begin
              nxt_st.ack_ok = 1'b0;
            end
          endcase
          // device drives low only for its own acknowledge
          nxt_st.sda_low = (st_ff.phase != ISP_RDATA) && nxt_st.ack_ok;
          if (st_ff.phase == ISP_RDATA) begin
            nxt_st.sda_low = 1'b0; // release for master ack
          end
        end else if (ninth_end) begin
          // ----------------------------------------
          // end of the ninth bit
          // ----------------------------------------
          nxt_st.ack_phase = 1'b0;
          nxt_st.bit_cnt = 4'h0;
          nxt_st.sda_low = 1'b0;
          unique case (st_ff.phase)
            ISP_ADDR: begin
              if (!st_ff.ack_ok) begin
                nxt_st.phase = ISP_IGNORE;
              end else if (st_ff.shift[0]) begin
                nxt_st.phase = ISP_RDATA;
                nxt_st.tx = rd_data;
                nxt_st.sda_low = isp_pull_low(rd_data[7]);
              end else begin
                nxt_st.phase = ISP_PTR;
              end
            end
            ISP_PTR: begin
              nxt_st.phase = ISP_WDATA;
            end
            ISP_WDATA: begin
              nxt_st.phase = ISP_WDATA;
            end
            ISP_RDATA: begin
              if (st_ff.master_nack) begin
                nxt_st.phase = ISP_IGNORE;
              end else begin
                nxt_st.tx = rd_data;
                nxt_st.sda_low = isp_pull_low(rd_data[7]);
              end
            end
            default: begin
              nxt_st.phase = ISP_IGNORE;
            end
          endcase
        end else if (st_ff.phase == ISP_RDATA) begin
          // ----------------------------------------
          // outgoing bits
          // ----------------------------------------
          // shift next outgoing bit on the falling edge
          nxt_st.tx = {st_ff.tx[6:0], 1'b0};
          nxt_st.sda_low = isp_pull_low(st_ff.tx[6]);
        end
      end

      // ----------------------------------------
      // read address advance
      // ----------------------------------------
      // plain increment: reads may run across rows, only writes wrap
      if (byte_done && st_ff.phase == ISP_RDATA) begin
        nxt_st.addr = st_ff.addr + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // sync stages reset high, the idle bus level, so no false edge follows
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff.scl_sync <= ISP_SYNC_RST;
      st_ff.sda_sync <= ISP_SYNC_RST;
      st_ff.phase <= ISP_IDLE;
      st_ff.bit_cnt <= 4'h0;
      st_ff.shift <= 8'h00;
      st_ff.tx <= 8'h00;
      st_ff.ack_phase <= 1'b0;
      st_ff.ack_ok <= 1'b0;
      st_ff.master_nack <= 1'b0;
      st_ff.addr <= ISP_ADDR_RST;
      st_ff.row_addr <= ISP_ADDR_RST;
      st_ff.wr_count <= 4'h0;
      st_ff.pending <= 1'b0;
      st_ff.sda_low <= 1'b0;
      st_ff.wr_pulse <= 1'b0;
      st_ff.wr_addr <= 8'h00;
      st_ff.wr_data <= 8'h00;
      st_ff.commit <= 1'b0;
      st_ff.busy_cnt <= 32'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only ever drive low
  assign sda_out = '{
    o: 1'b0,
    oe: st_ff.sda_low
  };

  // ----------------------------------------
  // shadow memory side
  // ----------------------------------------
  assign mem_wr = '{
    we: st_ff.wr_pulse,
    addr: st_ff.wr_addr,
    data: st_ff.wr_data
  };
  // counter shown as is; the memory answers it in the same cycle
  assign mem_addr = st_ff.addr;

  // ----------------------------------------
  // nonvolatile side
  // ----------------------------------------
  // row stays valid after the pulse for a slow programmer; count clears at the next start, a busy poll included
  assign nvm_req = '{
    commit: st_ff.commit,
    row_addr: st_ff.row_addr,
    count: st_ff.wr_count
  };
  assign nvm_busy = busy;

endmodule

//--- sim/isp_master.sv
// behavioural i2c master: scl and its open-drain side of sda
// assumes sda is the resolved wire; moves only on falling sys_clk
`timescale 1ns/10ps
module isp_master (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // three clocks before scl rises, so a slave ack has been let go
  task automatic start;
    sda_drv = 1'b1;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop;
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b1;
    tick(3);
    sda_drv = 1'b1;
    tick(6);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(3);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(1);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

//--- sim/isp_props.sv
// checker for the i2c slave port, bound to every isp_slave
// assumes the master holds scl low five clocks per bit
`timescale 1ns/10ps
module isp_props
  import isp_pkg::*;
#(
  parameter int NVM_PROGRAM_CYCLES = ISP_NVM_PROGRAM_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_i,
  input wire logic sda_i,
  input isp_pkg::isp_pin_out_s sda_out,
  input isp_pkg::isp_mem_wr_s mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] rd_data,
  input isp_pkg::isp_nvm_req_s nvm_req,
  input wire logic nvm_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // counts busy length; wide enough for the default program time
  logic [15:0] busy_cnt_ff;
  always_ff @(posedge sys_clk) begin
    busy_cnt_ff <= (rst || !nvm_busy) ? 16'h0000 : busy_cnt_ff + 16'h0001;
  end
  // commit and the busy count load on the same edge
  sequence s_prog;
    nvm_busy[*8];
  endsequence
  a_oe_scl_low: assert property ($changed(sda_out.oe) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_we_then_ack: assert property (mem_wr.we |-> ##[0:3] sda_out.oe)
    else $error("data byte written without acknowledge");
  a_commit_busy: assert property (nvm_req.commit |-> s_prog)
    else $error("commit not followed by busy");
  a_busy_len: assert property ($fell(nvm_busy) |-> busy_cnt_ff == 16'(NVM_PROGRAM_CYCLES))
    else $error("busy length wrong");
  a_commit_at_stop: assert property (nvm_req.commit |-> scl_i && sda_i)
    else $error("commit away from stop");
  a_commit_row: assert property (nvm_req.commit |-> nvm_req.row_addr[2:0] == 3'h0
    && nvm_req.count != 4'h0 && nvm_req.count <= 4'h8)
    else $error("commit row or count wrong");
  a_commit_once: assert property (nvm_req.commit |=> !nvm_req.commit)
    else $error("commit longer than one cycle");
  a_open_drain: assert property (sda_out.oe |-> sda_out.o == 1'b0 && !sda_i)
    else $error("sda driven high");
  a_busy_no_write: assert property (nvm_busy |-> !mem_wr.we)
    else $error("shadow write while programming");
  a_rst_quiet: assert property ($fell(rst) |-> !sda_out.oe && !nvm_busy && mem_addr == 8'h00)
    else $error("outputs not quiet after reset");
endmodule
bind isp_slave isp_props #(.NVM_PROGRAM_CYCLES(NVM_PROGRAM_CYCLES)) u_props (
  .sys_clk(sys_clk), .rst(rst), .scl_i(scl_i), .sda_i(sda_i), .sda_out(sda_out),
  .mem_wr(mem_wr), .mem_addr(mem_addr), .rd_data(rd_data), .nvm_req(nvm_req),
  .nvm_busy(nvm_busy));

//--- sim/isp_slave_tb.sv
// self-checking bench for isp_slave against the behavioural master
// assumes memory answers reads at once from a local array
`timescale 1ns/10ps
module isp_slave_tb;
  import isp_pkg::*;
  localparam int NVM_CYC = 200;
  logic sys_clk, rst, scl, sda_drv, sda, nvm_busy;
  isp_pin_out_s sda_out;
  isp_mem_wr_s mem_wr;
  isp_nvm_req_s nvm_req, last_req;
  logic [7:0] mem_addr;
  logic [7:0] mem [256];
  int fails = 0, n_compared = 0, n_we = 0, n_commit = 0, cycles = 0;
  assign sda = sda_drv & !sda_out.oe;
  isp_master m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  isp_slave #(.NVM_PROGRAM_CYCLES(NVM_CYC)) uut (.sys_clk(sys_clk), .rst(rst),
    .scl_i(scl), .sda_i(sda), .sda_out(sda_out), .mem_wr(mem_wr), .mem_addr(mem_addr),
    .rd_data(mem[mem_addr]), .nvm_req(nvm_req), .nvm_busy(nvm_busy));
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (mem_wr.we) mem[mem_wr.addr] <= mem_wr.data;
    if (mem_wr.we) n_we <= n_we + 1;
    if (nvm_req.commit) n_commit <= n_commit + 1;
    if (nvm_req.commit) last_req <= nvm_req;
    if (cycles == 20000) begin
      fails = fails + 1;
      final_report;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wack(input logic [7:0] d, input logic exp);
    logic a;
    m.wbyte(d, a);
    chk({7'h00, a}, {7'h00, exp});
  endtask
  task automatic rchk(input logic last, input logic [7:0] exp);
    logic [7:0] d;
    m.rbyte(last, d);
    chk(d, exp);
  endtask
  task automatic t_write;
    int c0 = n_commit;
    m.start();
    wack(8'hD6, 1'b1);
    wack(8'h26, 1'b1);
    wack(8'h11, 1'b1);
    wack(8'h22, 1'b1);
    wack(8'h33, 1'b1);
    chk(8'(n_commit - c0), 8'h00);
    m.stop();
    chk(8'(n_commit - c0), 8'h01);
    chk({4'h0, last_req.count}, 8'h03);
    chk(last_req.row_addr, 8'h20);
    chk(mem[8'h20], 8'h33);
    chk(mem[8'h27], 8'h22);
    chk(mem[8'h28], 8'h72);
    // address poll while programming is refused, then taken
    m.start();
    wack(8'hD6, 1'b0);
    m.stop();
    for (int i = 0; i < NVM_CYC && nvm_busy === 1'b1; i++) @(negedge sys_clk);
    m.start();
    wack(8'hD6, 1'b1);
    m.stop();
  endtask
  task automatic t_rstart;
    int c0 = n_commit;
    m.start();
    wack(8'hD6, 1'b1);
    wack(8'h30, 1'b1);
    wack(8'h77, 1'b1);
    m.start();
    wack(8'hD7, 1'b1);
    rchk(1'b0, 8'h6B);
    rchk(1'b1, 8'h68);
    m.stop();
    chk({7'h00, sda_out.oe}, 8'h00);
    chk(8'(n_commit - c0), 8'h00);
    chk(mem[8'h30], 8'h77);
  endtask
  task automatic t_badaddr;
    int w0 = n_we;
    m.start();
    wack(8'hD4, 1'b0);
    wack(8'h50, 1'b0);
    m.stop();
    chk(8'(n_we - w0), 8'h00);
  endtask
  task automatic t_abort;
    logic r;
    m.start();
    wack(8'hD6, 1'b1);
    wack(8'h40, 1'b1);
    for (int i = 0; i < 4; i++) m.bit_io(1'b0, r);
    m.start();
    wack(8'hD6, 1'b1);
    wack(8'h48, 1'b1);
    wack(8'h99, 1'b1);
    m.stop();
    chk(mem[8'h48], 8'h99);
    chk(last_req.row_addr, 8'h48);
  endtask
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    t_write;
    t_rstart;
    t_badaddr;
    t_abort;
    final_report;
  end
endmodule
